// ### verilog/ssf_core.sv
// execution block for stores, program loads, i/o, stack, shifts and flag operations
// How it works
// - offset write stores at pointer plus q
// - write via Z, then Z plus one
// - Z minus one, then write there, one cycle
// - program fetch into r0 or rd, three cycles
// - i/o read and write in one cycle
// - push stores register, one cycle, flags kept
// - pop restores register in two cycles, flags kept
// - left shifts: bit7 to carry, fill zero/carry
// - right shifts: bit0 to carry, zero/carry/sign fill
// - i/o bit set or clear, one cycle
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - set or clear any single flag
// - controller memory accesses add wait cycles
module ssf_core #(
  parameter int ADR_W = 8
) (
  input  logic             clk,
  input  logic             rst,
  input  logic             ce,
  input  logic             wb_cyc_i,
  input  logic             wb_stb_i,
  input  logic             wb_we_i,
  input  logic [ADR_W-1:0] wb_adr_i,
  input  logic [3:0]       wb_sel_i,
  input  logic [31:0]      wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             dm_req,
  output logic             dm_we,
  output logic [15:0]      dm_addr,
  output logic [7:0]       dm_wdata,
  input  logic [7:0]       dm_rdata,
  input  logic             dm_wait,
  output logic [15:0]      pm_addr,
  input  logic [7:0]       pm_rdata,
  output logic [5:0]       io_addr,
  output logic             io_re,
  output logic             io_we,
  output logic [7:0]       io_wdata,
  input  logic [7:0]       io_rdata,
  output logic             break_pulse,
  output logic             sleep_pulse,
  output logic             wdr_pulse
);
  import ssf_pkg::*;

  // opcode decode; loads and arithmetic live elsewhere and come back illegal
  function automatic ssf_op_type decode(input logic [15:0] w);
    ssf_op_type op;
    op = OP_ILLEGAL;
    casez (w)
      16'b0000_0000_0000_0000: op = OP_NO_OPERATION;
      16'b0000_11??_????_????,
      16'b0001_11??_????_????: begin
        if ({w[9], w[3:0]} == w[8:4]) begin
          op = OP_SHIFT;
        end
      end
      16'b10?0_??1?_????_????: op = OP_OFFSET_WRITE;
      16'b1001_001?_????0001: op = OP_WRITE_INC;
      16'b1001_001?_????0010: op = OP_WRITE_DEC;
      16'b1001_001?_????1111: op = OP_PUSH;
      16'b1001_000?_????0100,
      16'b1001_000?_????0101,
      16'b1001_0101_1100_1000: op = OP_FETCH_LOAD;
      16'b1001_000?_????1111: op = OP_POP;
      16'b1001_010?_????0010,
      16'b1001_010?_????0101,
      16'b1001_010?_????0110,
      16'b1001_010?_????0111: op = OP_SHIFT;
      16'b1001_0100_0???1000: op = OP_FLAG_SET;
      16'b1001_0100_1???1000: op = OP_FLAG_CLEAR;
      16'b1001_0101_1000_1000: op = OP_SLEEP;
      16'b1001_0101_1001_1000: op = OP_BREAK;
      16'b1001_0101_1010_1000: op = OP_WATCHDOG_RESTART;
      16'b1001_1010_????_????: op = OP_IO_BIT_SET;
      16'b1001_1000_????_????: op = OP_IO_BIT_CLEAR;
      16'b1011_0???_????_????: op = OP_IO_READ;
      16'b1011_1???_????_????: op = OP_IO_WRITE;
      16'b1111_101?_????0???: op = OP_BIT_TO_T;
      16'b1111_100?_????0???: op = OP_T_TO_BIT;
      default: op = OP_ILLEGAL;
    endcase
    return op;
  endfunction

  // which shift a shift-class word selects
  function automatic ssf_shift_type shift_kind(input logic [15:0] w);
    ssf_shift_type k;
    k = SH_SWAP;
    if (w[15:12] == 4'h0) begin
      k = SH_LSL_ZERO;
    end else if (w[15:12] == 4'h1) begin
      k = SH_ROL_CARRY;
    end else if (w[3:0] == 4'h6) begin
      k = SH_LSR_ZERO;
    end else if (w[3:0] == 4'h7) begin
      k = SH_ROR_CARRY;
    end else if (w[3:0] == 4'h5) begin
      k = SH_ASR_SIGNED;
    end
    return k;
  endfunction

  // execute cycles beyond the first, internal ram assumed
  function automatic logic [1:0] extra_cycles(input ssf_op_type op);
    logic [1:0] n;
    n = CYC_ONE - 2'd1;
    case (op)
      OP_FETCH_LOAD: n = CYC_LPM - 2'd1;
      OP_POP:        n = CYC_POP - 2'd1;
      OP_PUSH:       n = CYC_PUSH - 2'd1;
      OP_IO_READ,
      OP_IO_WRITE:   n = CYC_IO - 2'd1;
      OP_OFFSET_WRITE,
      OP_WRITE_INC,
      OP_WRITE_DEC:  n = CYC_STORE - 2'd1;
      default:       n = CYC_ONE - 2'd1;
    endcase
    return n;
  endfunction

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [3:0] sel);
    return {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  logic [7:0]    gpr_ff [REG_COUNT];
  ssf_state_type state_ff;
  ssf_op_type    op_ff;
  logic [15:0]   word_ff;
  logic [1:0]    cnt_ff;
  logic [15:0]   cyc_cnt_ff;
  logic          illegal_ff;
  logic [7:0]    flags_ff;
  logic [15:0]   sp_ff;
  logic [15:0]   nvm_base_ff;
  logic [4:0]    gpr_idx_ff;
  logic [15:0]   pm_addr_ff;
  logic          wb_ack_ff;
  logic [31:0]   wb_dat_ff;
  logic          break_ff;
  logic          sleep_ff;
  logic          wdr_ff;

  logic          access;
  logic          wr_fire;
  logic          idle;
  logic          start;
  logic [15:0]   new_word;
  logic          last;
  logic          mem_op;
  logic          commit;
  logic [4:0]    d_idx;
  logic [7:0]    rr;
  logic [2:0]    bit_sel;
  logic [15:0]   y_ptr;
  logic [15:0]   z_ptr;
  logic [15:0]   z_next;
  logic [15:0]   disp_addr;
  logic [7:0]    sh_result;
  logic [7:0]    sh_flags;
  logic [7:0]    io_bit_mask;

  ssf_mem_if mem ();

  // operand fields of the word in flight
  assign d_idx     = word_ff[8:4];
  assign rr        = gpr_ff[d_idx];
  assign bit_sel   = word_ff[2:0];
  assign y_ptr     = {gpr_ff[REG_Y_HI], gpr_ff[REG_Y_LO]};
  assign z_ptr     = {gpr_ff[REG_Z_HI], gpr_ff[REG_Z_LO]};
  assign disp_addr = (word_ff[3] ? y_ptr : z_ptr)
                     + {10'h000, word_ff[13], word_ff[11:10], word_ff[2:0]};
  assign io_bit_mask = 8'h01 << bit_sel;

  // bus handshake: writes land on the edge where the master sees ack
  assign access   = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  assign wr_fire  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_ff;
  assign idle     = (state_ff == ST_IDLE);
  assign new_word = merge16(word_ff, wb_dat_i[15:0], wb_sel_i);
  assign start    = wr_fire && idle && (wb_adr_i == ADR_W'(REG_INSTR));
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;

  // the action happens in the last execute cycle; memory ops may stretch it
  assign last   = (state_ff == ST_EXEC) && (cnt_ff == 2'd0);
  assign mem_op = (op_ff == OP_OFFSET_WRITE) || (op_ff == OP_WRITE_INC) ||
                  (op_ff == OP_WRITE_DEC) || (op_ff == OP_PUSH) || (op_ff == OP_POP);
  assign commit = last && (!mem_op || mem.done);

  // data memory request, address by addressing form
  assign mem.req   = last && mem_op;
  assign mem.we    = (op_ff != OP_POP);
  assign mem.wdata = rr;
  always_comb begin
    z_next   = z_ptr + 16'h0001;
    mem.addr = z_ptr;
    case (op_ff)
      OP_OFFSET_WRITE: mem.addr = disp_addr;
      OP_WRITE_INC:    mem.addr = z_ptr;
      OP_WRITE_DEC: begin
        z_next   = z_ptr - 16'h0001;
        mem.addr = z_next;
      end
      OP_PUSH:         mem.addr = sp_ff;
      OP_POP:          mem.addr = sp_ff + 16'h0001;
      default:         mem.addr = z_ptr;
    endcase
  end

  // i/o space: reads feed the register file, bit ops read-modify-write in one cycle
  assign io_addr  = (op_ff == OP_IO_READ || op_ff == OP_IO_WRITE) ?
                    {word_ff[10:9], word_ff[3:0]} : {1'b0, word_ff[7:3]};
  assign io_re    = last && (op_ff == OP_IO_READ || op_ff == OP_IO_BIT_SET ||
                             op_ff == OP_IO_BIT_CLEAR);
  assign io_we    = last && (op_ff == OP_IO_WRITE || op_ff == OP_IO_BIT_SET ||
                             op_ff == OP_IO_BIT_CLEAR);
  always_comb begin
    io_wdata = rr;
    if (op_ff == OP_IO_BIT_SET) begin
      io_wdata = io_rdata | io_bit_mask;
    end else if (op_ff == OP_IO_BIT_CLEAR) begin
      io_wdata = io_rdata & ~io_bit_mask;
    end
  end

  assign pm_addr     = pm_addr_ff;
  assign break_pulse = break_ff;
  assign sleep_pulse = sleep_ff;
  assign wdr_pulse   = wdr_ff;

  ssf_shift_unit u_shift (
    .kind      (shift_kind(word_ff)),
    .value     (rr),
    .flags_in  (flags_ff),
    .result    (sh_result),
    .flags_out (sh_flags)
  );

  ssf_mem_port u_mem (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .mem      (mem.port),
    .nvm_base (nvm_base_ff),
    .dm_req   (dm_req),
    .dm_we    (dm_we),
    .dm_addr  (dm_addr),
    .dm_wdata (dm_wdata),
    .dm_rdata (dm_rdata),
    .dm_wait  (dm_wait)
  );

  // sequencer: idle until software writes a word, then count execute cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      op_ff      <= OP_NO_OPERATION;
      word_ff    <= INSTR_RST;
      cnt_ff     <= 2'd0;
      cyc_cnt_ff <= 16'h0000;
      illegal_ff <= 1'b0;
      pm_addr_ff <= 16'h0000;
    end else if (ce) begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff   <= ST_EXEC;
            word_ff    <= new_word;
            op_ff      <= decode(new_word);
            cnt_ff     <= extra_cycles(decode(new_word));
            cyc_cnt_ff <= 16'h0000;
            illegal_ff <= (decode(new_word) == OP_ILLEGAL);
            pm_addr_ff <= z_ptr;
          end
        end
        ST_EXEC: begin
          cyc_cnt_ff <= cyc_cnt_ff + 16'h0001;
          if (cnt_ff != 2'd0) begin
            cnt_ff <= cnt_ff - 2'd1;
          end else if (commit) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // register file: bus writes only while idle, so they never race an instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        gpr_ff[i] <= 8'h00;
      end
    end else if (ce) begin
      if (wr_fire && idle && (wb_adr_i == ADR_W'(REG_GPR_DATA)) && wb_sel_i[0]) begin
        gpr_ff[gpr_idx_ff] <= wb_dat_i[7:0];
      end else if (commit) begin
        case (op_ff)
          OP_FETCH_LOAD: begin
            gpr_ff[(word_ff == OPC_LPM_R0) ? REG_R0 : d_idx] <= pm_rdata;
            if (word_ff[3:0] == 4'h5) begin
              gpr_ff[REG_Z_LO] <= z_next[7:0];
              gpr_ff[REG_Z_HI] <= z_next[15:8];
            end
          end
          OP_WRITE_INC,
          OP_WRITE_DEC: begin
            gpr_ff[REG_Z_LO] <= z_next[7:0];
            gpr_ff[REG_Z_HI] <= z_next[15:8];
          end
          OP_IO_READ:  gpr_ff[d_idx] <= io_rdata;
          OP_POP:      gpr_ff[d_idx] <= mem.rdata;
          OP_SHIFT:    gpr_ff[d_idx] <= sh_result;
          OP_T_TO_BIT: gpr_ff[d_idx][bit_sel] <= flags_ff[FLAG_T];
          default: begin
          end
        endcase
      end
    end
  end

  // flag register: besides bus writes while idle, only shifts, the transfer-flag copy and flag set/clear change it
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
    end else if (ce) begin
      if (wr_fire && idle && (wb_adr_i == ADR_W'(REG_STATUS)) && wb_sel_i[0]) begin
        flags_ff <= wb_dat_i[7:0];
      end else if (commit) begin
        case (op_ff)
          OP_SHIFT:      flags_ff <= sh_flags;
          OP_BIT_TO_T:   flags_ff[FLAG_T] <= rr[bit_sel];
          OP_FLAG_SET:   flags_ff[word_ff[6:4]] <= 1'b1;
          OP_FLAG_CLEAR: flags_ff[word_ff[6:4]] <= 1'b0;
          default: begin
          end
        endcase
      end
    end
  end

  // stack pointer: push stores then moves down, pop moves up then reads
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_ff <= SP_RST;
    end else if (ce) begin
      if (wr_fire && idle && (wb_adr_i == ADR_W'(REG_STACK_PTR))) begin
        sp_ff <= merge16(sp_ff, wb_dat_i[15:0], wb_sel_i);
      end else if (commit && op_ff == OP_PUSH) begin
        sp_ff <= sp_ff - 16'h0001;
      end else if (commit && op_ff == OP_POP) begin
        sp_ff <= sp_ff + 16'h0001;
      end
    end
  end

  // control instructions hand a one-cycle pulse to the debug, power and watchdog units
  always_ff @(posedge clk) begin
    if (rst) begin
      break_ff <= 1'b0;
      sleep_ff <= 1'b0;
      wdr_ff   <= 1'b0;
    end else if (ce) begin
      break_ff <= commit && (op_ff == OP_BREAK);
      sleep_ff <= commit && (op_ff == OP_SLEEP);
      wdr_ff   <= commit && (op_ff == OP_WATCHDOG_RESTART);
    end
  end

  // bus slave: one wait state, read data captured with ack, unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_ff   <= 1'b0;
      wb_dat_ff   <= 32'h0000_0000;
      gpr_idx_ff  <= 5'd0;
      nvm_base_ff <= NVM_BASE_RST;
    end else if (ce) begin
      wb_ack_ff <= access;
      if (wr_fire && (wb_adr_i == ADR_W'(REG_GPR_INDEX)) && wb_sel_i[0]) begin
        gpr_idx_ff <= wb_dat_i[4:0];
      end
      if (wr_fire && (wb_adr_i == ADR_W'(REG_NVM_BASE))) begin
        nvm_base_ff <= merge16(nvm_base_ff, wb_dat_i[15:0], wb_sel_i);
      end
      if (access) begin
        if (wb_adr_i == ADR_W'(REG_INSTR)) begin
          wb_dat_ff <= {16'h0000, word_ff};
        end else if (wb_adr_i == ADR_W'(REG_STATUS)) begin
          wb_dat_ff <= {22'h000000, illegal_ff, !idle, flags_ff};
        end else if (wb_adr_i == ADR_W'(REG_GPR_INDEX)) begin
          wb_dat_ff <= {27'h0000000, gpr_idx_ff};
        end else if (wb_adr_i == ADR_W'(REG_GPR_DATA)) begin
          wb_dat_ff <= {24'h000000, gpr_ff[gpr_idx_ff]};
        end else if (wb_adr_i == ADR_W'(REG_STACK_PTR)) begin
          wb_dat_ff <= {16'h0000, sp_ff};
        end else if (wb_adr_i == ADR_W'(REG_NVM_BASE)) begin
          wb_dat_ff <= {16'h0000, nvm_base_ff};
        end else if (wb_adr_i == ADR_W'(REG_CYCLES)) begin
          wb_dat_ff <= {16'h0000, cyc_cnt_ff};
        end else begin
          wb_dat_ff <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// ### verilog/ssf_pkg.sv
// constants, encodings and types shared by the store/shift/flag execution block
package ssf_pkg;

  // register offsets on the bus, byte addresses of aligned words
  localparam logic [7:0] REG_INSTR     = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_GPR_INDEX = 8'h08;
  localparam logic [7:0] REG_GPR_DATA  = 8'h0c;
  localparam logic [7:0] REG_STACK_PTR = 8'h10;
  localparam logic [7:0] REG_NVM_BASE  = 8'h14;
  localparam logic [7:0] REG_CYCLES    = 8'h18;

  // reset values
  localparam logic [15:0] INSTR_RST     = 16'h0000;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [15:0] SP_RST        = 16'h0000;
  localparam logic [15:0] NVM_BASE_RST  = 16'h1000;

  // cpu_flag_register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // status word fields above the flags
  localparam int STATUS_BUSY_BIT = 8;
  localparam int STATUS_ILL_BIT  = 9;

  // register file layout
  localparam int         REG_COUNT = 32;
  localparam logic [4:0] REG_R0    = 5'd0;
  localparam logic [4:0] REG_Y_LO  = 5'd28;
  localparam logic [4:0] REG_Y_HI  = 5'd29;
  localparam logic [4:0] REG_Z_LO  = 5'd30;
  localparam logic [4:0] REG_Z_HI  = 5'd31;

  // cycle counts for internal ram
  localparam logic [1:0] CYC_STORE = 2'd1;
  localparam logic [1:0] CYC_IO    = 2'd1;
  localparam logic [1:0] CYC_PUSH  = 2'd1;
  localparam logic [1:0] CYC_POP   = 2'd2;
  localparam logic [1:0] CYC_LPM   = 2'd3;
  localparam logic [1:0] CYC_ONE   = 2'd1;

  // the operand-less program_memory_fetch_load word
  localparam logic [15:0] OPC_LPM_R0 = 16'h95c8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } ssf_state_type;

  typedef enum logic [4:0] {
    OP_ILLEGAL, OP_OFFSET_WRITE, OP_WRITE_INC, OP_WRITE_DEC, OP_FETCH_LOAD,
    OP_IO_READ, OP_IO_WRITE, OP_PUSH, OP_POP, OP_SHIFT, OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR, OP_BIT_TO_T, OP_T_TO_BIT, OP_FLAG_SET, OP_FLAG_CLEAR,
    OP_BREAK, OP_NO_OPERATION, OP_SLEEP, OP_WATCHDOG_RESTART
  } ssf_op_type;

  typedef enum logic [2:0] {
    SH_LSL_ZERO, SH_ROL_CARRY, SH_LSR_ZERO, SH_ROR_CARRY, SH_ASR_SIGNED, SH_SWAP
  } ssf_shift_type;

endpackage

// ### verilog/ssf_mem_if.sv
// request and answer bundle between the core and the data memory port
interface ssf_mem_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        done;

  modport core (output req, output we, output addr, output wdata, input rdata, input done);
  modport port (input req, input we, input addr, input wdata, output rdata, output done);
endinterface

// ### verilog/ssf_shift_unit.sv
// shift, rotate and nibble swap datapath with its flag results
module ssf_shift_unit (
  input  ssf_pkg::ssf_shift_type kind,
  input  logic [7:0]             value,
  input  logic [7:0]             flags_in,
  output logic [7:0]             result,
  output logic [7:0]             flags_out
);
  import ssf_pkg::*;

  logic c_new;

  // result and carry per kind, then the flags each kind updates
  always_comb begin
    result    = value;
    c_new     = flags_in[FLAG_C];
    flags_out = flags_in;
    case (kind)
      SH_LSL_ZERO: begin
        result = {value[6:0], 1'b0};
        c_new  = value[7];
      end
      SH_ROL_CARRY: begin
        result = {value[6:0], flags_in[FLAG_C]};
        c_new  = value[7];
      end
      SH_LSR_ZERO: begin
        result = {1'b0, value[7:1]};
        c_new  = value[0];
      end
      SH_ROR_CARRY: begin
        result = {flags_in[FLAG_C], value[7:1]};
        c_new  = value[0];
      end
      SH_ASR_SIGNED: begin
        result = {value[7], value[7:1]};
        c_new  = value[0];
      end
      default: begin
        result = {value[3:0], value[7:4]};
      end
    endcase
    // swap keeps every flag, so only the shifts touch them
    if (kind != SH_SWAP) begin
      flags_out[FLAG_C] = c_new;
      flags_out[FLAG_Z] = (result == 8'h00);
      flags_out[FLAG_N] = result[7];
      flags_out[FLAG_V] = result[7] ^ c_new;
    end
    // half carry only follows left moves, taken from the old bit 3
    if (kind == SH_LSL_ZERO || kind == SH_ROL_CARRY) begin
      flags_out[FLAG_H] = value[3];
    end
  end

endmodule

// ### verilog/ssf_mem_port.sv
// data memory port that adds the controller wait for the nonvolatile range
module ssf_mem_port (
  input  logic        clk,
  input  logic        rst,
  input  logic        ce,
  ssf_mem_if.port     mem,
  input  logic [15:0] nvm_base,
  output logic        dm_req,
  output logic        dm_we,
  output logic [15:0] dm_addr,
  output logic [7:0]  dm_wdata,
  input  logic [7:0]  dm_rdata,
  input  logic        dm_wait
);
  import ssf_pkg::*;

  logic setup_ff;
  logic is_nvm;

  assign is_nvm = (mem.addr >= nvm_base);

  // one setup cycle before any controller access; cleared when the access ends
  always_ff @(posedge clk) begin
    if (rst) begin
      setup_ff <= 1'b0;
    end else if (ce) begin
      if (mem.req && mem.done) begin
        setup_ff <= 1'b0;
      end else if (mem.req && is_nvm) begin
        setup_ff <= 1'b1;
      end
    end
  end

  // controller range waits a cycle, then as long as the memory side stalls
  assign dm_req   = mem.req && (!is_nvm || setup_ff);
  assign mem.done = dm_req && !dm_wait;
  assign dm_we    = mem.we;
  assign dm_addr  = mem.addr;
  assign dm_wdata = mem.wdata;
  assign mem.rdata = dm_rdata;

endmodule

// ### test/ssf_core_chk.sv
// port-level assertions for ssf_core
module ssf_core_chk
  import ssf_pkg::*;
(
  input logic        clk,
  input logic        rst,
  input logic        wb_ack_o,
  input logic        dm_req,
  input logic        dm_we,
  input logic        dm_wait,
  input logic [15:0] dm_addr,
  input logic        io_re,
  input logic        io_we,
  input logic [7:0]  io_rdata,
  input logic [7:0]  io_wdata,
  input logic        break_pulse,
  input logic        sleep_pulse,
  input logic        wdr_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // the bus answer is a single pulse
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held too long");
  // i/o strobes sit in the cycle right after the instruction write
  property p_io_time; io_we |-> $past(wb_ack_o) && !$past(io_we); endproperty
  a_io_time: assert property (p_io_time) else $error("i/o strobe late");
  // a bit set or clear changes one bit at most
  property p_io_bit; io_re && io_we |-> $countones(io_wdata ^ io_rdata) <= 1; endproperty
  a_io_bit: assert property (p_io_bit) else $error("i/o bit op wrong");
  // internal stores go out at once
  property p_st_fast; $rose(dm_req) && dm_we && dm_addr < NVM_BASE_RST |-> $past(wb_ack_o);
  endproperty
  a_st_fast: assert property (p_st_fast) else $error("store late");
  // controller range needs a setup cycle first
  property p_nvm; $rose(dm_req) && dm_addr >= NVM_BASE_RST |-> !$past(wb_ack_o); endproperty
  a_nvm: assert property (p_nvm) else $error("controller access too early");
  // a completed transfer is released next cycle
  property p_done; dm_req && !dm_wait |=> !dm_req; endproperty
  a_done: assert property (p_done) else $error("transfer repeated");
  // control pulses last one cycle
  property p_pulse; break_pulse || sleep_pulse || wdr_pulse |=> !(break_pulse || sleep_pulse
    || wdr_pulse); endproperty
  a_pulse: assert property (p_pulse) else $error("control pulse held");
  // and come two cycles after the instruction write
  property p_pulse_t; break_pulse || sleep_pulse || wdr_pulse |-> $past(wb_ack_o, 2);
  endproperty
  a_pulse_t: assert property (p_pulse_t) else $error("control pulse mistimed");
endmodule

bind ssf_core ssf_core_chk chk_u (.*);

// ### test/ssf_mem_model.sv
// data memory, program memory and i/o space facing ssf_core
module ssf_mem_model (
  input  logic        clk,
  input  logic        dm_req,
  input  logic        dm_we,
  input  logic [15:0] dm_addr,
  input  logic [7:0]  dm_wdata,
  output logic [7:0]  dm_rdata,
  output logic        dm_wait,
  input  logic [15:0] pm_addr,
  output logic [7:0]  pm_rdata,
  input  logic [5:0]  io_addr,
  input  logic        io_re,
  input  logic        io_we,
  input  logic [7:0]  io_wdata,
  output logic [7:0]  io_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] io_mem [0:63];
  logic [1:0] stall_ff = 2'h0;
  // controller range stalls two cycles so the core must honour dm_wait
  assign dm_wait = dm_req && dm_addr >= 16'h1000 && stall_ff != 2'h2;
  // idle lines show the inverse, never a stale byte
  assign dm_rdata = (dm_req && !dm_we) ? mem[dm_addr] : ~mem[dm_addr];
  assign pm_rdata = pm_addr[7:0] ^ 8'h5a;
  assign io_rdata = io_re ? io_mem[io_addr] : ~io_mem[io_addr];
  // storage changes only at a completing edge
  always_ff @(posedge clk) begin
    stall_ff <= (dm_req && dm_wait) ? stall_ff + 2'h1 : 2'h0;
    if (dm_req && dm_we && !dm_wait)
      mem[dm_addr] <= dm_wdata;
    if (io_we)
      io_mem[io_addr] <= io_wdata;
  end
endmodule

// ### test/ssf_core_tb.sv
// self-checking bench for ssf_core
module ssf_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, dm_req, dm_we, dm_wait, io_re, io_we;
  logic        break_pulse, sleep_pulse, wdr_pulse;
  logic [15:0] dm_addr, pm_addr;
  logic [7:0]  dm_wdata, dm_rdata, pm_rdata, io_wdata, io_rdata;
  logic [5:0]  io_addr;
  logic [31:0] q;
  int          bad_count = 0;
  int          n_compared = 0;
  logic [2:0]  seen_pulse = 3'h0;
  // opcode, r1 before, flags before, r1 after, flags after
  logic [47:0] rows [12] = '{48'h0c11_88_00_10_29, 48'h1c11_40_01_81_0c,
    48'h9416_01_10_00_1b, 48'h9417_02_01_81_0c, 48'h9415_81_00_c0_05,
    48'h9412_3c_a5_c3_a5, 48'hfa13_08_00_08_40, 48'hf810_00_40_01_40,
    48'h0000_55_3c_55_3c, 48'h9598_55_3c_55_3c,
    48'h9588_55_3c_55_3c, 48'h95a8_55_3c_55_3c};
  ssf_core dut_u (.*);
  ssf_mem_model mem_u (.*);
  always #4 clk = ~clk;
  // control pulses are kept sticky so a one-cycle pulse cannot slip past the check
  always @(posedge clk) seen_pulse <= seen_pulse | {break_pulse, sleep_pulse, wdr_pulse};
  task automatic complete_run;
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // one classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s, q, e);
  endtask
  task automatic sr(input logic [4:0] i, input logic [7:0] v);
    wb(1'b1, REG_GPR_INDEX, {27'h0, i});
    wb(1'b1, REG_GPR_DATA, {24'h0, v});
  endtask
  task automatic gc(input string s, input logic [4:0] i, input logic [7:0] e);
    wb(1'b1, REG_GPR_INDEX, {27'h0, i});
    rc(s, REG_GPR_DATA, {24'h0, e});
  endtask
  // start a word and poll busy, bounded
  task automatic ex(input logic [15:0] op);
    int n;
    wb(1'b1, REG_INSTR, {16'h0, op});
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[STATUS_BUSY_BIT] !== 1'b0 && n < 50);
    chk("busy", {31'h0, n >= 50}, 32'h0);
    if (n >= 50) begin
      complete_run();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rc("status", REG_STATUS, 32'h0);
    rc("nvm_base", REG_NVM_BASE, 32'h1000);
    rc("unmapped", 8'h1c, 32'h0);
    foreach (rows[i]) begin
      sr(5'h01, rows[i][31:24]);
      wb(1'b1, REG_STATUS, {24'h0, rows[i][23:16]});
      ex(rows[i][47:32]);
      gc("row_reg", 5'h01, rows[i][15:8]);
      rc("row_flags", REG_STATUS, {24'h0, rows[i][7:0]});
    end
    chk("pulses", {29'h0, seen_pulse}, 32'h7);
    for (int s = 0; s < 8; s++) begin
      wb(1'b1, REG_STATUS, 32'h0);
      ex(16'h9408 | 16'(s << 4));
      rc("flag_set", REG_STATUS, 32'h1 << s);
      wb(1'b1, REG_STATUS, 32'hff);
      ex(16'h9488 | 16'(s << 4));
      rc("flag_clr", REG_STATUS, 32'hff ^ (32'h1 << s));
    end
    sr(5'h01, 8'ha7);
    sr(5'h1e, 8'h00);
    sr(5'h1f, 8'h02);
    ex(16'h9211);
    chk("st_inc_mem", {24'h0, mem_u.mem[16'h0200]}, 32'ha7);
    gc("st_inc_z", 5'h1e, 8'h01);
    sr(5'h01, 8'h3b);
    ex(16'h9212);
    chk("st_dec_mem", {24'h0, mem_u.mem[16'h0200]}, 32'h3b);
    rc("st_dec_cyc", REG_CYCLES, 32'h1);
    ex(16'h8215);
    chk("std_mem", {24'h0, mem_u.mem[16'h0205]}, 32'h3b);
    gc("std_z", 5'h1e, 8'h00);
    sr(5'h1f, 8'h10);
    ex(16'h8210);
    chk("nvm_mem", {24'h0, mem_u.mem[16'h1000]}, 32'h3b);
    wb(1'b0, REG_CYCLES, 32'h0);
    chk("nvm_extra", q, 32'h4);
    wb(1'b1, REG_STACK_PTR, 32'h0100);
    ex(16'h921f);
    chk("push_mem", {24'h0, mem_u.mem[16'h0100]}, 32'h3b);
    rc("push_sp", REG_STACK_PTR, 32'h00ff);
    ex(16'h902f);
    gc("pop_reg", 5'h02, 8'h3b);
    rc("pop_cyc", REG_CYCLES, 32'h2);
    ex(OPC_LPM_R0);
    gc("lpm_r0", 5'h00, 8'h5a);
    rc("lpm_cyc", REG_CYCLES, 32'h3);
    ex(16'h9025);
    gc("lpm_z", 5'h1e, 8'h01);
    ex(16'hb815);
    ex(16'h9a2a);
    ex(16'hb025);
    gc("io_read", 5'h02, 8'h3f);
    ex(16'h982b);
    chk("io_clr", {24'h0, mem_u.io_mem[5]}, 32'h37);
    ex(16'h0c12);
    rc("illegal", REG_STATUS, 32'h27f);
    complete_run();
  end
endmodule
